// [hw/mci_pkg.sv]
`default_nettype none
package mci_pkg;
	// Bus address: fixed upper bits, last bit from the select strap
	localparam logic [5:0] SLAVE_ADDR_HI = 6'h25;
	localparam logic RW_WRITE = 1'b0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Register indices
	localparam logic [6:0] IDX_GAIN = 7'h31;
	localparam logic [6:0] IDX_SELECT = 7'h32;
	localparam logic [6:0] IDX_PORT = 7'h33;
	localparam logic [6:0] IDX_UNUSED = 7'h30;

	// Field positions
	localparam int GAIN_LSB = 0;
	localparam int RESTORE_BIT = 6;
	localparam int SELECT_LSB = 0;
	localparam int LAYOUT_LSB = 0;
	localparam int ROLE_LSB = 3;
	localparam int RESYNC_BIT = 6;
	localparam int SKIP_BIT = 7;

	// Reserved bit masks, set bits must be written as zero
	localparam logic [7:0] RSV_MASK_GAIN = 8'h80;
	localparam logic [7:0] RSV_MASK_SELECT = 8'hf8;
	localparam logic [7:0] RSV_MASK_PORT = 8'h20;

	// Field codes after reset
	localparam logic [5:0] GAIN_MINUS_11DB = 6'h00;
	localparam logic [2:0] SELECT_CH1 = 3'h0;
	localparam logic [1:0] ROLE_SLAVE = 2'h0;
	localparam logic [2:0] LAYOUT_I2S = 3'h0;

	// Register values after reset
	localparam logic [7:0] GAIN_RST = {1'b0, 1'b1, GAIN_MINUS_11DB};
	localparam logic [7:0] SELECT_RST = {5'h00, SELECT_CH1};
	localparam logic [7:0] PORT_RST = {1'b0, 1'b1, 1'b0, ROLE_SLAVE, LAYOUT_I2S};

	// Link timing, standard-mode rate
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
endpackage
`default_nettype wire

// [hw/mci_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface mci_if;
	// Host drives the clock, both ends may pull the data line low
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// Wired-AND of the open-drain lines with pull-ups
	assign scl = scl_host_oe ? scl_host_o : 1'b1;
	assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);

	modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
		output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// [hw/mci_dev.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - Address upper six bits fixed at 100101.
// - Address low bit follows select strap.
// - Respond only to own slave address.
// - Receive only; read bit is refused.
// - Master frames start, address, data, stop.
// - Standard-mode bus timing on both ends.
// - Burst: address, first index, then data.
// - Index advances by one per byte.
// - Index wraps from 33h to 31h.
// - Undefined index gets no acknowledge.
// - Bytes are eight bits, MSB first.
// - Registers live at indices 31h, 32h, 33h.
// - 31h: reserved, restore, six-bit gain.
// - 32h: three-bit input select, channel one.
// - 33h: skip, resync, role, layout fields.
// - Port role resets to slave.
// - Restore, resync normal; gain -11 dB; filter on.
// - Master writes reserved bits as zero.
// - Index 30h accepts no data.
// - Restore bit zero reloads all defaults.
// - Resync bit zero requests resynchronisation.
// - Skip bit one passes DC through.
module mci_dev
	import mci_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Two-wire link
	mci_if.dev link,
	// Address select strap
	input wire logic addr_sel,
	// Mode fields
	output logic [5:0] gain_step_code,
	output logic mode_regs_restore,
	output logic [2:0] input_select,
	output logic dc_filter_skip,
	output logic resync_request,
	output logic [1:0] port_role,
	output logic [2:0] sample_layout,
	// Write strobe for the audio core
	output logic reg_write_pulse
);
	import mci_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_INDEX,
		ST_DATA,
		ST_ACK,
		ST_SKIP
	} mci_dev_st_t;

	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] sync_c;
	logic [2:0] filt;
	logic [2:0] filt_d;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	mci_dev_st_t state;
	mci_dev_st_t ack_next;
	mci_dev_st_t next_after;
	logic [3:0] bit_cnt;
	logic [7:0] shift_in;
	logic byte_done;
	logic byte_ok;
	logic sda_low;
	logic [6:0] reg_index;
	logic [7:0] reg_gain;
	logic [7:0] reg_select;
	logic [7:0] reg_port;
	logic write_now;

	// Three-stage synchronisers for clock, data and strap
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 3'h3;
			sync_b <= 3'h3;
			sync_c <= 3'h3;
		end else begin
			sync_a <= {addr_sel, link.sda, link.scl};
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			filt <= 3'h3;
			filt_d <= 3'h3;
		end else begin
			filt <= (sync_b & ~(sync_b ^ sync_c)) | (filt & (sync_b ^ sync_c));
			filt_d <= filt;
		end
	end

	// Edges and bus conditions
	assign scl_rise = filt[0] & ~filt_d[0];
	assign scl_fall = ~filt[0] & filt_d[0];
	assign start_seen = filt[0] & filt_d[0] & ~filt[1] & filt_d[1];
	assign stop_seen = filt[0] & filt_d[0] & filt[1] & ~filt_d[1];
	assign byte_done = (bit_cnt == BITS_PER_BYTE);

	// Verdict on a completed byte
	always_comb begin
		byte_ok = 1'b0;
		next_after = ST_SKIP;
		unique case (state)
			ST_ADDR: begin
				// Own address with write direction only
				if (shift_in[7:1] == {SLAVE_ADDR_HI, filt[2]}
					&& shift_in[0] == RW_WRITE) begin
					byte_ok = 1'b1;
					next_after = ST_INDEX;
				end
			end
			ST_INDEX: begin
				// Only the three defined indices are taken
				if (shift_in == {1'b0, IDX_GAIN} || shift_in == {1'b0, IDX_SELECT}
					|| shift_in == {1'b0, IDX_PORT}) begin
					byte_ok = 1'b1;
					next_after = ST_DATA;
				end
			end
			ST_DATA: begin
				byte_ok = 1'b1;
				next_after = ST_DATA;
			end
			default: begin
				byte_ok = 1'b0;
				next_after = ST_SKIP;
			end
		endcase
	end

	// Byte framing and acknowledge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			ack_next <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift_in <= 8'h00;
			sda_low <= 1'b0;
		end else if (start_seen) begin
			// Any start, repeated or not, opens a new burst
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			sda_low <= 1'b0;
		end else if (stop_seen) begin
			state <= ST_IDLE;
			sda_low <= 1'b0;
		end else if (scl_rise && !byte_done
			&& (state == ST_ADDR || state == ST_INDEX || state == ST_DATA)) begin
			// Eight bits in, MSB first
			shift_in <= {shift_in[6:0], filt[1]};
			bit_cnt <= bit_cnt + 4'h1;
		end else if (scl_fall && state == ST_ACK) begin
			// Release the line after the ninth clock
			sda_low <= 1'b0;
			bit_cnt <= 4'h0;
			state <= ack_next;
		end else if (scl_fall && byte_done
			&& (state == ST_ADDR || state == ST_INDEX || state == ST_DATA)) begin
			if (byte_ok) begin
				sda_low <= 1'b1;
				state <= ST_ACK;
				ack_next <= next_after;
			end else begin
				state <= ST_SKIP;
			end
		end
	end

	// Open-drain data output
	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = sda_low;

	assign write_now = scl_fall && byte_done && state == ST_DATA;

	// Register index: loaded by the index byte, stepped by each data byte
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_index <= IDX_GAIN;
		end else if (scl_fall && byte_done && state == ST_INDEX && byte_ok) begin
			reg_index <= shift_in[6:0];
		end else if (write_now) begin
			if (reg_index == IDX_PORT) begin
				reg_index <= IDX_GAIN;
			end else begin
				reg_index <= reg_index + 7'h01;
			end
		end
	end

	// Mode registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_gain <= GAIN_RST;
			reg_select <= SELECT_RST;
			reg_port <= PORT_RST;
		end else if (write_now) begin
			unique case (reg_index)
				IDX_GAIN: begin
					if (!shift_in[RESTORE_BIT]) begin
						// Restore request reloads every register
						reg_gain <= GAIN_RST;
						reg_select <= SELECT_RST;
						reg_port <= PORT_RST;
					end else begin
						reg_gain <= shift_in;
					end
				end
				IDX_SELECT: begin
					reg_select <= shift_in;
				end
				IDX_PORT: begin
					reg_port <= shift_in;
				end
				default: begin
					reg_gain <= reg_gain;
				end
			endcase
		end
	end

	// Strobe for every accepted data byte
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_write_pulse <= 1'b0;
		end else begin
			reg_write_pulse <= write_now;
		end
	end

	// Field outputs straight from the registers
	assign gain_step_code = reg_gain[GAIN_LSB +: 6];
	assign mode_regs_restore = reg_gain[RESTORE_BIT];
	assign input_select = reg_select[SELECT_LSB +: 3];
	assign dc_filter_skip = reg_port[SKIP_BIT];
	assign resync_request = reg_port[RESYNC_BIT];
	assign port_role = reg_port[ROLE_LSB +: 2];
	assign sample_layout = reg_port[LAYOUT_LSB +: 3];
endmodule
`default_nettype wire

// [hw/mci_host.sv]
`timescale 1ns/10ps
`default_nettype none
module mci_host
	import mci_pkg::*;
#(
	parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Two-wire link
	mci_if.host link,
	// Write command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [6:0] cmd_dev_addr,
	input wire logic [6:0] cmd_index,
	input wire logic [1:0] cmd_len,
	input wire logic [23:0] cmd_data,
	// Result
	output logic done_pulse,
	output logic nack_seen
);
	import mci_pkg::*;

	typedef enum {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} mci_host_st_t;

	mci_host_st_t state;
	logic [15:0] div_cnt;
	logic tick;
	logic [1:0] phase;
	logic [3:0] bit_n;
	logic [2:0] bytes_left;
	logic [39:0] tx_sh;
	logic scl_low;
	logic sda_low;
	logic [2:0] sda_s;
	logic sda_f;

	// Reserved bits of the register at an index
	function automatic logic [7:0] rsv_mask(input logic [6:0] idx);
		rsv_mask = (idx == IDX_GAIN) ? RSV_MASK_GAIN :
			(idx == IDX_SELECT) ? RSV_MASK_SELECT : RSV_MASK_PORT;
	endfunction

	// Index of data byte n, wrapping like the device
	function automatic logic [6:0] idx_at(input logic [6:0] first, input logic [1:0] n);
		logic [6:0] v;
		v = first;
		for (int i = 0; i < 2; i++) begin
			if (i < int'(n)) begin
				v = (v == IDX_PORT) ? IDX_GAIN : v + 7'h01;
			end
		end
		idx_at = v;
	endfunction

	// Quarter-bit enable at the standard-mode rate
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
		end else if (div_cnt == 16'(QUARTER_CYC - 1)) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end
	assign tick = (div_cnt == 16'(QUARTER_CYC - 1));

	// Data line synchroniser for acknowledge sampling
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sda_s <= 3'h7;
			sda_f <= 1'b1;
		end else begin
			sda_s <= {sda_s[1:0], link.sda};
			if (sda_s[1] == sda_s[2]) begin
				sda_f <= sda_s[1];
			end
		end
	end

	assign cmd_ready = (state == H_IDLE);

	// Transfer sequencer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= H_IDLE;
			phase <= 2'h0;
			bit_n <= 4'h0;
			bytes_left <= 3'h0;
			tx_sh <= 40'h0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			nack_seen <= 1'b0;
		end else if (state == H_IDLE) begin
			if (cmd_valid) begin
				// Address with write bit, index, then masked data bytes
				tx_sh <= {cmd_dev_addr, RW_WRITE, 1'b0, cmd_index,
					cmd_data[7:0] & ~rsv_mask(idx_at(cmd_index, 2'h0)),
					cmd_data[15:8] & ~rsv_mask(idx_at(cmd_index, 2'h1)),
					cmd_data[23:16] & ~rsv_mask(idx_at(cmd_index, 2'h2))};
				bytes_left <= 3'h2 + {1'b0, cmd_len};
				nack_seen <= 1'b0;
				phase <= 2'h0;
				state <= H_START;
			end
		end else if (tick) begin
			phase <= phase + 2'h1;
			unique case (state)
				H_START: begin
					if (phase == 2'h1) sda_low <= 1'b1;
					if (phase == 2'h2) scl_low <= 1'b1;
					if (phase == 2'h3) begin
						bit_n <= 4'h0;
						state <= H_BIT;
					end
				end
				H_BIT: begin
					// Eight bits MSB first, ninth released for acknowledge
					if (phase == 2'h0) sda_low <= (bit_n != BITS_PER_BYTE) & ~tx_sh[39];
					if (phase == 2'h1) scl_low <= 1'b0;
					if (phase == 2'h3) begin
						scl_low <= 1'b1;
						if (bit_n == BITS_PER_BYTE) begin
							bit_n <= 4'h0;
							bytes_left <= bytes_left - 3'h1;
							nack_seen <= sda_f;
							if (sda_f || bytes_left == 3'h1) state <= H_STOP;
						end else begin
							tx_sh <= {tx_sh[38:0], 1'b0};
							bit_n <= bit_n + 4'h1;
						end
					end
				end
				H_STOP: begin
					if (phase == 2'h0) sda_low <= 1'b1;
					if (phase == 2'h1) scl_low <= 1'b0;
					if (phase == 2'h2) sda_low <= 1'b0;
					if (phase == 2'h3) state <= H_IDLE;
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	// End of a transfer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= tick && state == H_STOP && phase == 2'h3;
		end
	end

	// Open-drain drivers
	assign link.scl_host_o = 1'b0;
	assign link.scl_host_oe = scl_low;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = sda_low;
endmodule
`default_nettype wire

// [testbench/mci_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module mci_asserts #(
	parameter int QUARTER_CYC = 10
) (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Link lines
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_host_o,
	input wire logic scl_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe
);
	localparam int MIN_HALF = 2 * QUARTER_CYC - 2;
	localparam int ACK_MAX = 6 * QUARTER_CYC;
	logic scl_q;
	logic sda_q;
	logic [15:0] run_cnt;
	logic [3:0] bit_cnt;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// Length of the present clock level, saturating
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			run_cnt <= 16'h0000;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl != scl_q) begin
				run_cnt <= 16'h0001;
			end else if (run_cnt != 16'hffff) begin
				run_cnt <= run_cnt + 16'h0001;
			end
		end
	end

	// Clock rises since the last start, nine to a byte
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 4'h0;
		end else if (scl && scl_q && !sda && sda_q) begin
			bit_cnt <= 4'h0;
		end else if (scl && !scl_q) begin
			bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
		end
	end

	dev_pull_low_a: assert property (sda_dev_oe |-> !sda_dev_o)
		else $error("device drives the data line high");
	ack_ninth_bit_a: assert property ($rose(sda_dev_oe) |-> !scl && bit_cnt == 4'h8)
		else $error("acknowledge begins outside the ninth bit");
	ack_release_a: assert property ($fell(sda_dev_oe) |-> !scl && bit_cnt == 4'h0)
		else $error("acknowledge released at the wrong moment");
	ack_bounded_a: assert property ($rose(sda_dev_oe) |-> ##[1:ACK_MAX] !sda_dev_oe)
		else $error("acknowledge held too long");
	dev_hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
		else $error("device changes data while clock high");
	scl_low_min_a: assert property (scl && !scl_q |-> run_cnt >= MIN_HALF)
		else $error("clock low period too short");
	scl_high_min_a: assert property (!scl && scl_q |-> run_cnt >= MIN_HALF)
		else $error("clock high period too short");
	scl_open_drain_a: assert property (scl_host_oe |-> !scl_host_o)
		else $error("host drives the clock line high");
endmodule
`default_nettype wire

// [testbench/mode_control_i2c_port_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module mode_control_i2c_port_tb;
	import mci_pkg::*;
	localparam int Q = 10;
	typedef struct packed {
		logic strap;
		logic [6:0] addr;
		logic [6:0] idx;
		logic [1:0] len;
		logic [23:0] data;
		logic nack;
	} mci_row_t;
	// Own address is 7'h4a with the strap low, 7'h4b with it high
	localparam mci_row_t ROWS [9] = '{
		'{1'b0, 7'h4a, 7'h31, 2'h1, 24'h000055, 1'b0},
		'{1'b0, 7'h4a, 7'h32, 2'h1, 24'h0000fd, 1'b0},
		'{1'b0, 7'h4a, 7'h33, 2'h3, 24'h2a079b, 1'b0},
		'{1'b0, 7'h4a, 7'h31, 2'h3, 24'h5e036a, 1'b0},
		'{1'b0, 7'h4b, 7'h31, 2'h1, 24'h000041, 1'b1},
		'{1'b0, 7'h4a, 7'h30, 2'h1, 24'h000077, 1'b1},
		'{1'b0, 7'h4a, 7'h34, 2'h1, 24'h000077, 1'b1},
		'{1'b0, 7'h4a, 7'h32, 2'h0, 24'h000000, 1'b0},
		'{1'b1, 7'h4b, 7'h33, 2'h1, 24'h000047, 1'b0}
	};
	logic clk_sys;
	logic rst_n;
	logic addr_sel;
	logic [5:0] gain_step_code;
	logic mode_regs_restore;
	logic [2:0] input_select;
	logic dc_filter_skip;
	logic resync_request;
	logic [1:0] port_role;
	logic [2:0] sample_layout;
	logic reg_write_pulse;
	logic cmd_valid;
	logic cmd_ready;
	logic [6:0] cmd_dev_addr;
	logic [6:0] cmd_index;
	logic [1:0] cmd_len;
	logic [23:0] cmd_data;
	logic done_pulse;
	logic nack_seen;
	logic [7:0] m31;
	logic [7:0] m32;
	logic [7:0] m33;
	logic [23:0] seen_fields;
	logic [23:0] exp_p;
	int fail_count;
	int compares;
	int pulses;

	mci_if link_if();
	mci_dev mci_dev_inst(.clk_sys, .rst_n, .link(link_if), .addr_sel, .gain_step_code,
		.mode_regs_restore, .input_select, .dc_filter_skip, .resync_request, .port_role,
		.sample_layout, .reg_write_pulse);
	mci_host #(.QUARTER_CYC(Q)) mci_host_inst(.clk_sys, .rst_n, .link(link_if), .cmd_valid,
		.cmd_ready, .cmd_dev_addr, .cmd_index, .cmd_len, .cmd_data, .done_pulse, .nack_seen);
	mci_asserts #(.QUARTER_CYC(Q)) mci_asserts_inst(.clk_sys, .rst_n, .scl(link_if.scl),
		.sda(link_if.sda), .scl_host_o(link_if.scl_host_o), .scl_host_oe(link_if.scl_host_oe),
		.sda_dev_o(link_if.sda_dev_o), .sda_dev_oe(link_if.sda_dev_oe));

	// All mode fields in one word
	assign seen_fields = {7'h00, gain_step_code, mode_regs_restore, input_select,
		dc_filter_skip, resync_request, port_role, sample_layout};

	// Clock at 100 MHz
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Count stored data bytes
	always @(posedge clk_sys) begin
		if (reg_write_pulse === 1'b1) begin
			pulses++;
		end
	end

	function automatic logic [23:0] exp_fields();
		return {7'h00, m31[5:0], m31[6], m32[2:0], m33[7], m33[6], m33[4:3], m33[2:0]};
	endfunction

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Register model: index steps by one and wraps, reserved bits land as zero
	task automatic model(input mci_row_t r);
		logic [6:0] i;
		logic [7:0] b;
		i = r.idx;
		for (int k = 0; k < r.len; k++) begin
			b = r.data[8*k +: 8];
			if (i == IDX_GAIN && !b[RESTORE_BIT]) begin
				m31 = GAIN_RST;
				m32 = SELECT_RST;
				m33 = PORT_RST;
			end else if (i == IDX_GAIN) begin
				m31 = b & ~RSV_MASK_GAIN;
			end else if (i == IDX_SELECT) begin
				m32 = b & ~RSV_MASK_SELECT;
			end else begin
				m33 = b & ~RSV_MASK_PORT;
			end
			i = (i == IDX_PORT) ? IDX_GAIN : i + 7'h01;
		end
	endtask

	// One write frame through the host, bounded wait for its end
	task automatic run(input mci_row_t r);
		int n;
		@(negedge clk_sys);
		addr_sel = r.strap;
		repeat (8) @(negedge clk_sys);
		pulses = 0;
		check("ready when idle", {23'h0, cmd_ready}, 24'h1);
		cmd_dev_addr = r.addr;
		cmd_index = r.idx;
		cmd_len = r.len;
		cmd_data = r.data;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		n = 0;
		while (done_pulse !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 3000) begin
			fail_count++;
			test_done();
		end
	endtask

	initial begin
		rst_n = 1'b0;
		addr_sel = 1'b0;
		cmd_valid = 1'b0;
		cmd_dev_addr = 7'h00;
		cmd_index = 7'h00;
		cmd_len = 2'h0;
		cmd_data = 24'h000000;
		fail_count = 0;
		compares = 0;
		pulses = 0;
		m31 = GAIN_RST;
		m32 = SELECT_RST;
		m33 = PORT_RST;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		check("fields after reset", seen_fields, exp_fields());
		foreach (ROWS[r]) begin
			run(ROWS[r]);
			if (!ROWS[r].nack) begin
				model(ROWS[r]);
			end
			exp_p = ROWS[r].nack ? 24'h0 : {22'h0, ROWS[r].len};
			check("nack", {23'h0, nack_seen}, {23'h0, ROWS[r].nack});
			check("write pulses", pulses[23:0], exp_p);
			check("fields", seen_fields, exp_fields());
		end
		// Reset while the address is acknowledged; the strap is still high from the last row
		cmd_dev_addr = ROWS[8].addr;
		cmd_index = ROWS[3].idx;
		cmd_len = ROWS[3].len;
		cmd_data = ROWS[3].data;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// Start and eight bits take about 360 clocks, the acknowledge then stands about 40
		repeat (378) @(negedge clk_sys);
		check("ack before reset", {23'h0, link_if.sda_dev_oe}, 24'h1);
		@(negedge clk_sys);
		rst_n = 1'b0;
		m31 = GAIN_RST;
		m32 = SELECT_RST;
		m33 = PORT_RST;
		@(negedge clk_sys);
		check("fields in reset", seen_fields, exp_fields());
		check("dev released", {23'h0, link_if.sda_dev_oe}, 24'h0);
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		run(ROWS[1]);
		model(ROWS[1]);
		check("fields after abort", seen_fields, exp_fields());
		check("nack after abort", {23'h0, nack_seen}, 24'h0);
		test_done();
	end
endmodule
`default_nettype wire
